// [src/lmwd_pkg.sv]
// Purpose: Shared constants and types for the LCD multiplex waveform driver.
// Assumes: 250 MHz system clock, APB register access, 32-bit data.
// Notes: Register offsets are byte addresses, one aligned word per register.
package lmwd_pkg;
    // Timing
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned SRC_MAX_HZ = 4096;
    localparam int unsigned TICK_CYCLES = CLK_HZ / SRC_MAX_HZ;

    // Register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PADSEL = 8'h04;
    localparam logic [7:0] ADDR_FRAME = 8'h08;
    localparam logic [7:0] ADDR_BIAS = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [1:0] ADDR_DATA_PAGE = 2'h1;
    localparam int unsigned NUM_DATA_REGS = 16;

    // Field positions
    localparam int unsigned CTRL_MUX_LSB = 0;
    localparam int unsigned CTRL_HALT_BIT = 2;
    localparam int unsigned FRM_FREQ_LSB = 0;
    localparam int unsigned FRM_DIV_LSB = 5;
    localparam int unsigned BIAS_CFG_W = 6;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] PADSEL_RST = 8'hFF;
    localparam logic [7:0] FRAME_RST = 8'h00;
    localparam logic [7:0] BIAS_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // Multiplex scheme codes
    localparam logic [1:0] MUX_STATIC = 2'h0;
    localparam logic [1:0] MUX_TWO = 2'h1;
    localparam logic [1:0] MUX_THREE = 2'h2;
    localparam logic [1:0] MUX_FOUR = 2'h3;

    // Drive level codes, V0 lowest to V3 highest
    localparam logic [1:0] LVL_0 = 2'h0;
    localparam logic [1:0] LVL_1 = 2'h1;
    localparam logic [1:0] LVL_2 = 2'h2;
    localparam logic [1:0] LVL_3 = 2'h3;

    // Bias generator configuration, bit 5 down to bit 0
    typedef struct packed {
        logic [1:0] bias_pump_clock_sel;
        logic bias_gen_standby;
        logic bias_ratio_sel;
        logic bias_gen_off;
        logic bias_internal_ref_en;
    } lmwd_bias_cfg_t;

    typedef enum logic {ST_STOPPED, ST_RUNNING} lmwd_state_t;
endpackage : lmwd_pkg

// [src/lmwd_top.sv]
// Purpose: Segment LCD waveform timing generator with APB register file.
// Assumes: Zero-wait APB slave; levels are codes for the external bias ladder.
// Notes: Operation list below; pins idle at level 0 while stopped.
// Operation
// - Time up to 32 segment lines against up to four commons, static or multiplexed.
// - Static: one segment per pin, backplane on common zero.
// - Static: only data bits 0 and 4 matter.
// - Two-way: two segments per pin, commons zero and one.
// - Two-way: only data bits 0, 1, 4, 5 matter.
// - Three-way: pins 0-30 carry three segments, pin 31 is third common.
// - Three-way: bits 3 and 7 ignored.
// - Scheme field: 00 static, 01 two-way, 10 three-way.
// - Waveforms run while the halt bit is 0.
// - Pad group gets LCD drive when its select bit is 1.
// - Low nibble drives pin 2N, high nibble pin 2N+1; 1 means on.
// - Bias ratio bit 2: 1 half bias, 0 one-third bias.
// - Frame rate is source over twice divider times multiplex count.
// - Source select picks 512, 1024, 2048 or 4096 Hz.
// - Divider field divides the source by code plus one.
// - Data writes show from next frame; reads return shown value.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module lmwd_top #(
    parameter int unsigned TICK_CYCLES = lmwd_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Panel drive
    output logic [31:0][1:0] seg_level_o,
    output logic [1:0][1:0] com_level_o,
    output logic [31:0] seg_lcd_en_o,
    output logic frame_start_o,
    // Bias generator control
    output lmwd_pkg::lmwd_bias_cfg_t bias_cfg_o
);
    localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

    logic [7:0] ctrl_q;
    logic [7:0] padsel_q;
    logic [7:0] frame_q;
    logic [7:0] bias_q;
    logic [15:0][7:0] pend_q;
    logic [15:0][7:0] disp_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    logic [1:0] mux_scheme_sel;
    logic waveform_halt;
    logic [1:0] source_freq_sel;
    logic [2:0] frame_div_sel;
    logic half_bias;

    lmwd_pkg::lmwd_state_t state_q;
    logic [TW-1:0] tick_cnt_q;
    logic [2:0] presc_q;
    logic [2:0] div_cnt_q;
    logic [1:0] slot_q;
    logic pol_q;
    logic base_tick;
    logic src_tick;
    logic step;
    logic last_slot;
    logic running;
    logic frame_start;

    logic apb_setup;
    logic apb_write;
    logic data_hit;
    logic [3:0] data_idx;
    logic [31:0] rd_data;
    logic rd_err;
    logic [3:0][1:0] com_lvl;
    logic [31:0][1:0] seg_lvl;

    assign mux_scheme_sel = ctrl_q[lmwd_pkg::CTRL_MUX_LSB +: 2];
    assign waveform_halt = ctrl_q[lmwd_pkg::CTRL_HALT_BIT];
    assign source_freq_sel = frame_q[lmwd_pkg::FRM_FREQ_LSB +: 2];
    assign frame_div_sel = frame_q[lmwd_pkg::FRM_DIV_LSB +: 3];
    assign half_bias = bias_q[2];
    assign bias_cfg_o = lmwd_pkg::lmwd_bias_cfg_t'(bias_q[lmwd_pkg::BIAS_CFG_W-1:0]);

    // APB decode; zero wait, so every access phase completes
    assign pready_o = 1'b1;
    assign prdata_o = prdata_q;
    assign pslverr_o = pslverr_q;
    assign apb_setup = psel_i && !penable_i;
    assign apb_write = psel_i && penable_i && pwrite_i && !pslverr_q;
    assign data_hit = paddr_i[7:6] == lmwd_pkg::ADDR_DATA_PAGE && paddr_i[1:0] == 2'h0;
    assign data_idx = paddr_i[5:2];

    // Read mux; unused nibble bits read as zero for the active scheme
    always_comb begin
        logic [3:0] nib_mask;
        logic [7:0] byte_mask;
        nib_mask = 4'hF >> (2'h3 - mux_scheme_sel);
        byte_mask = {nib_mask, nib_mask};
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        if (data_hit) begin
            if (data_idx == 4'hF && mux_scheme_sel >= lmwd_pkg::MUX_THREE) begin
                byte_mask[7:4] = 4'h0;
            end
            if (data_idx == 4'hF && mux_scheme_sel == lmwd_pkg::MUX_FOUR) begin
                byte_mask[3:0] = 4'h0;
            end
            rd_data[7:0] = disp_q[data_idx] & byte_mask;
        end else begin
            case (paddr_i)
                lmwd_pkg::ADDR_CTRL: rd_data[7:0] = ctrl_q & 8'h07;
                lmwd_pkg::ADDR_PADSEL: rd_data[7:0] = padsel_q;
                lmwd_pkg::ADDR_FRAME: rd_data[7:0] = frame_q & 8'hE3;
                lmwd_pkg::ADDR_BIAS: rd_data[7:0] = bias_q & 8'h3F;
                lmwd_pkg::ADDR_STATUS: rd_data[3:0] = {slot_q, pol_q, running};
                default: rd_err = 1'b1;
            endcase
        end
    end

    // Read data and error captured in the setup phase
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (apb_setup) begin
            prdata_q <= pwrite_i ? 32'h0000_0000 : rd_data;
            pslverr_q <= rd_err || (pwrite_i && paddr_i == lmwd_pkg::ADDR_STATUS);
        end
    end

    // Configuration registers
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q <= lmwd_pkg::CTRL_RST;
            padsel_q <= lmwd_pkg::PADSEL_RST;
            frame_q <= lmwd_pkg::FRAME_RST;
            bias_q <= lmwd_pkg::BIAS_RST;
        end else if (apb_write && !data_hit) begin
            case (paddr_i)
                lmwd_pkg::ADDR_CTRL: ctrl_q <= pwdata_i[7:0] & 8'h07;
                lmwd_pkg::ADDR_PADSEL: padsel_q <= pwdata_i[7:0];
                lmwd_pkg::ADDR_FRAME: frame_q <= pwdata_i[7:0] & 8'hE3;
                lmwd_pkg::ADDR_BIAS: bias_q <= pwdata_i[7:0] & 8'h3F;
                default: ;
            endcase
        end
    end

    // Pending segment data; software writes land here first
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pend_q <= {lmwd_pkg::NUM_DATA_REGS{lmwd_pkg::DATA_RST}};
        end else if (apb_write && data_hit) begin
            pend_q[data_idx] <= pwdata_i[7:0];
        end
    end

    // Shown data follows pending only at frame start or while stopped
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            disp_q <= {lmwd_pkg::NUM_DATA_REGS{lmwd_pkg::DATA_RST}};
        end else if (frame_start || state_q == lmwd_pkg::ST_STOPPED) begin
            disp_q <= pend_q;
        end
    end

    // 4096 Hz base tick
    assign base_tick = tick_cnt_q == TW'(TICK_CYCLES - 1);
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tick_cnt_q <= '0;
        end else if (base_tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + TW'(1);
        end
    end

    // Source select: codes 0 to 3 step every 8, 4, 2 or 1 base ticks
    assign src_tick = base_tick
        && ((presc_q & (3'h7 >> source_freq_sel)) == (3'h7 >> source_freq_sel));
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            presc_q <= 3'h0;
        end else if (base_tick) begin
            presc_q <= presc_q + 3'h1;
        end
    end

    // Divide by code plus one; >= tolerates a field rewritten mid-count
    assign step = src_tick && div_cnt_q >= frame_div_sel;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_cnt_q <= 3'h0;
        end else if (step) begin
            div_cnt_q <= 3'h0;
        end else if (src_tick) begin
            div_cnt_q <= div_cnt_q + 3'h1;
        end
    end

    // Slot sequencer: 2 x mux steps per frame
    assign running = state_q == lmwd_pkg::ST_RUNNING;
    assign last_slot = slot_q >= mux_scheme_sel;
    assign frame_start = step && !waveform_halt
        && (!running || (last_slot && pol_q));
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= lmwd_pkg::ST_STOPPED;
            slot_q <= 2'h0;
            pol_q <= 1'b0;
        end else if (step) begin
            case (state_q)
                lmwd_pkg::ST_STOPPED: begin
                    slot_q <= 2'h0;
                    pol_q <= 1'b0;
                    if (!waveform_halt) begin
                        state_q <= lmwd_pkg::ST_RUNNING;
                    end
                end
                lmwd_pkg::ST_RUNNING: begin
                    if (last_slot) begin
                        slot_q <= 2'h0;
                        pol_q <= !pol_q;
                        if (pol_q && waveform_halt) begin
                            state_q <= lmwd_pkg::ST_STOPPED; // Halt only at frame end
                        end
                    end else begin
                        slot_q <= slot_q + 2'h1;
                    end
                end
                default: state_q <= lmwd_pkg::ST_STOPPED;
            endcase
        end
    end

    // Common levels: selected at an extreme, other active ones mid-rail, unused at level 0
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            if (!running || 2'(k) > mux_scheme_sel) begin
                com_lvl[k] = lmwd_pkg::LVL_0;
            end else if (slot_q == 2'(k)) begin
                com_lvl[k] = pol_q ? lmwd_pkg::LVL_0 : lmwd_pkg::LVL_3;
            end else if (half_bias) begin
                com_lvl[k] = lmwd_pkg::LVL_1;
            end else begin
                com_lvl[k] = pol_q ? lmwd_pkg::LVL_2 : lmwd_pkg::LVL_1;
            end
        end
    end

    // Segment levels per pin
    genvar p;
    generate
        for (p = 0; p < 32; p++) begin : g_seg
            logic [3:0] nib;
            logic seg_on;
            assign nib = disp_q[p / 2][(p % 2) * 4 +: 4];
            assign seg_on = nib[slot_q];
            assign seg_lcd_en_o[p] = padsel_q[7 - p / 4];
            always_comb begin
                if (!running) begin
                    seg_lvl[p] = lmwd_pkg::LVL_0;
                end else if (p == 31 && mux_scheme_sel >= lmwd_pkg::MUX_THREE) begin
                    seg_lvl[p] = com_lvl[2];
                end else if (p == 30 && mux_scheme_sel == lmwd_pkg::MUX_FOUR) begin
                    seg_lvl[p] = com_lvl[3];
                end else if (seg_on) begin
                    seg_lvl[p] = pol_q ? lmwd_pkg::LVL_3 : lmwd_pkg::LVL_0;
                end else if (mux_scheme_sel == lmwd_pkg::MUX_STATIC || half_bias) begin
                    seg_lvl[p] = pol_q ? lmwd_pkg::LVL_0 : lmwd_pkg::LVL_3;
                end else begin
                    seg_lvl[p] = pol_q ? lmwd_pkg::LVL_1 : lmwd_pkg::LVL_2;
                end
            end
        end
    endgenerate

    // Registered pin levels, one cycle behind the sequencer
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            seg_level_o <= '0;
            com_level_o <= '0;
            frame_start_o <= 1'b0;
        end else begin
            seg_level_o <= seg_lvl;
            com_level_o <= com_lvl[1:0];
            frame_start_o <= frame_start;
        end
    end

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    property p_halt_stops;
        (running && step && last_slot && pol_q && waveform_halt) |=> !running;
    endproperty
    a_halt_stops: assert property (p_halt_stops) else $error("halt missed frame end");
    property p_runs_unhalted;
        (running && !waveform_halt) |=> running;
    endproperty
    a_runs_unhalted: assert property (p_runs_unhalted) else $error("stopped unhalted");
    property p_shown_stable;
        (running && !frame_start) |=> $stable(disp_q);
    endproperty
    a_shown_stable: assert property (p_shown_stable) else $error("shown data changed");
    property p_pad_groups;
        seg_lcd_en_o[0] == padsel_q[7] && seg_lcd_en_o[31] == padsel_q[0];
    endproperty
    a_pad_groups: assert property (p_pad_groups) else $error("pad group mapping wrong");
    property p_static_com;
        (running && mux_scheme_sel == lmwd_pkg::MUX_STATIC && slot_q == 2'h0)
            |=> com_level_o[0] == ($past(pol_q) ? lmwd_pkg::LVL_0 : lmwd_pkg::LVL_3)
                && com_level_o[1] == lmwd_pkg::LVL_0;
    endproperty
    a_static_com: assert property (p_static_com) else $error("static backplane wrong");
    property p_third_common;
        (running && mux_scheme_sel == lmwd_pkg::MUX_THREE && slot_q == 2'h2)
            |=> seg_level_o[31] == ($past(pol_q) ? lmwd_pkg::LVL_0 : lmwd_pkg::LVL_3);
    endproperty
    a_third_common: assert property (p_third_common) else $error("pin 31 not common");
    property p_pol_flip;
        (running && step && last_slot) |=> pol_q != $past(pol_q) && slot_q == 2'h0;
    endproperty
    a_pol_flip: assert property (p_pol_flip) else $error("polarity did not flip");
    property p_div_count;
        (src_tick && div_cnt_q < frame_div_sel) |=> div_cnt_q == $past(div_cnt_q) + 3'h1;
    endproperty
    a_div_count: assert property (p_div_count) else $error("divider miscounted");
    property p_static_mask;
        (apb_setup && !pwrite_i && data_hit && mux_scheme_sel == lmwd_pkg::MUX_STATIC)
            |=> (prdata_o & 32'hFFFF_FFEE) == 32'h0000_0000;
    endproperty
    a_static_mask: assert property (p_static_mask) else $error("static read not masked");
    property p_two_mask;
        (apb_setup && !pwrite_i && data_hit && mux_scheme_sel == lmwd_pkg::MUX_TWO)
            |=> (prdata_o & 32'hFFFF_FFCC) == 32'h0000_0000;
    endproperty
    a_two_mask: assert property (p_two_mask) else $error("two-way read not masked");
    property p_three_mask;
        (apb_setup && !pwrite_i && data_hit && mux_scheme_sel == lmwd_pkg::MUX_THREE)
            |=> (prdata_o & 32'hFFFF_FF88) == 32'h0000_0000;
    endproperty
    a_three_mask: assert property (p_three_mask) else $error("three-way read not masked");
    property p_seg_on_static;
        (running && mux_scheme_sel == lmwd_pkg::MUX_STATIC && disp_q[0][4])
            |=> seg_level_o[1] != com_level_o[0];
    endproperty
    a_seg_on_static: assert property (p_seg_on_static) else $error("segment not driven");
    c_frame_start: cover property (frame_start);
    c_stop: cover property (running && step && waveform_halt && last_slot && pol_q);
    c_three_way: cover property (running && mux_scheme_sel == lmwd_pkg::MUX_THREE && slot_q == 2'h2);
    c_half_bias: cover property (running && half_bias && mux_scheme_sel == lmwd_pkg::MUX_TWO);
endmodule : lmwd_top
`default_nettype wire

// [sim/lmwd_glass.sv]
// Purpose: Passive segment glass that tallies net DC per segment and frame.
// Assumes: Level codes feed a bias ladder; half bias merges the middle taps.
// Notes: Any segment left with net DC against a wired backplane at a frame boundary bumps dc_bad_o.
`timescale 1ns/1ps
`default_nettype none
module lmwd_glass (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Drive from the waveform block
    input wire logic [31:0][1:0] seg_level_i,
    input wire logic [1:0][1:0] com_level_i,
    input wire logic frame_start_i,
    input wire logic half_i,
    // Backplanes actually wired to the glass
    input wire logic [1:0] com_used_i,
    // Tally
    output var int dc_bad_o
);
    int acc[32][2];

    // Half bias ties codes 1 and 2 to one tap
    function automatic int volts(logic [1:0] c);
        return (half_i && c >= 2'h2) ? int'(c) - 1 : int'(c);
    endfunction : volts

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            dc_bad_o <= 0;
            foreach (acc[p, c]) acc[p][c] <= 0;
        end else begin
            foreach (acc[p, c]) begin
                // Pulse cycle still shows the closing slot, so it ends the sum
                if (frame_start_i && com_used_i[c]
                    && acc[p][c] + volts(seg_level_i[p]) - volts(com_level_i[c]) != 0) begin
                    dc_bad_o <= dc_bad_o + 1;
                end
                acc[p][c] <= frame_start_i ? 0
                    : acc[p][c] + volts(seg_level_i[p]) - volts(com_level_i[c]);
            end
        end
    end
endmodule : lmwd_glass
`default_nettype wire

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the LCD waveform block.
// Assumes: TICK_CYCLES of 4, so one 4096 Hz source step is 4 clocks.
// Notes: Levels are sampled mid-slot; the 4096 Hz source keeps the run brief.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int TICK = 4;
    localparam int SLOT = 32;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [31:0][1:0] seg_level_o;
    logic [1:0][1:0] com_level_o;
    logic [31:0] seg_lcd_en_o;
    logic frame_start_o;
    lmwd_pkg::lmwd_bias_cfg_t bias_cfg_o;
    int dc_bad;
    int bad_count = 0;
    int comparisons = 0;
    logic [7:0] dat[16];
    logic half = 1'b0;
    logic [1:0] com_used = 2'h1;
    logic [31:0] rd;
    logic er;

    always #2 clk_i = ~clk_i;

    lmwd_top #(.TICK_CYCLES(TICK)) i_dut (.clk_i(clk_i), .reset_i(reset_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .seg_level_o(seg_level_o), .com_level_o(com_level_o),
        .seg_lcd_en_o(seg_lcd_en_o), .frame_start_o(frame_start_o), .bias_cfg_o(bias_cfg_o));

    lmwd_glass i_glass (.clk_i(clk_i), .reset_i(reset_i), .seg_level_i(seg_level_o),
        .com_level_i(com_level_o), .frame_start_i(frame_start_o),
        .half_i(bias_cfg_o.bias_ratio_sel), .com_used_i(com_used), .dc_bad_o(dc_bad));

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask : cmp

    // Hold the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            final_report();
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        // Callers look at outputs only once the edge's updates have settled
        @(negedge clk_i);
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        cmp(rd, e, "read");
        cmp({31'h0, er}, {31'h0, ee}, "slverr");
    endtask : rd_chk

    task automatic wait_frame();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (frame_start_o !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            bad_count++;
            final_report();
        end
    endtask : wait_frame

    function automatic logic [1:0] lvl_com(int j, int s, int p);
        if (j == s) return p ? 2'h0 : 2'h3;
        return (half || p == 0) ? 2'h1 : 2'h2;
    endfunction : lvl_com

    function automatic logic [1:0] lvl_seg(logic on, int p, int m);
        if (on) return p ? 2'h3 : 2'h0;
        if (half || m == 1) return p ? 2'h0 : 2'h3;
        return p ? 2'h1 : 2'h2;
    endfunction : lvl_seg

    task automatic check_frame(input int m);
        int k, i, s, p;
        logic [1:0] e;
        wait_frame();
        repeat (SLOT / 2 - 1) @(negedge clk_i);
        for (k = 0; k < 2 * m; k++) begin
            s = k % m;
            p = k / m;
            for (i = 0; i < 32; i++) begin
                if (m >= 3 && i == 31) e = lvl_com(2, s, p);
                else if (m == 4 && i == 30) e = lvl_com(3, s, p);
                else e = lvl_seg(dat[i / 2][4 * (i % 2) + s], p, m);
                cmp(seg_level_o[i], e, "seg");
            end
            cmp(com_level_o[0], lvl_com(0, s, p), "com0");
            if (m > 1) cmp(com_level_o[1], lvl_com(1, s, p), "com1");
            repeat (SLOT) @(negedge clk_i);
        end
    endtask : check_frame

    initial begin
        int i, md, f, dv, r, b0, n;
        logic [7:0] ad, mk;
        logic [31:0] e;
        void'($urandom(32'hAC2D));
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        for (i = 0; i < 5; i++) begin
            ad = (i == 4) ? 8'h40 : 8'(4 * i);
            rd_chk(ad, (i == 1) ? 32'hFF : 32'h0, 1'b0);
        end
        rd_chk(8'h14, 32'h0, 1'b1);
        apb(1'b1, 8'h10, 32'h5);
        cmp({31'h0, er}, 32'h1, "ro");
        r = $urandom_range(255);
        apb(1'b1, 8'h04, 32'(r));
        for (i = 0; i < 32; i++) e[i] = r[7 - i / 4];
        cmp(seg_lcd_en_o, e, "padsel");
        apb(1'b1, 8'h04, 32'hFF);
        for (md = 0; md < 4; md++) begin
            half = (md == 1);
            com_used = (md == 0) ? 2'h1 : 2'h3;
            apb(1'b1, 8'h0C, half ? 32'hF5 : 32'hF1);
            cmp({26'h0, bias_cfg_o}, half ? 32'h35 : 32'h31, "bias");
            apb(1'b1, 8'h08, 32'hE3);
            apb(1'b1, 8'h00, 32'(md));
            for (i = 0; i < 16; i++) begin
                dat[i] = 8'($urandom);
                apb(1'b1, 8'h40 + 8'(4 * i), {24'h0, dat[i]});
            end
            wait_frame();
            @(negedge clk_i);
            b0 = dc_bad;
            check_frame(md + 1);
            wait_frame();
            r = $urandom_range(14);
            ad = 8'h40 + 8'(4 * r);
            mk = (md == 0) ? 8'h11 : (md == 1) ? 8'h33 : (md == 2) ? 8'h77 : 8'hFF;
            apb(1'b1, ad, {24'h0, ~dat[r]});
            rd_chk(ad, {24'h0, dat[r] & mk}, 1'b0);
            dat[r] = ~dat[r];
            check_frame(md + 1);
            rd_chk(ad, {24'h0, dat[r] & mk}, 1'b0);
            cmp(32'(dc_bad), 32'(b0), "dc");
        end
        for (f = 0; f < 4; f++) begin
            md = f % 3;
            dv = (f == 3) ? $urandom_range(7) : (md == 2 ? 6 : 4);
            apb(1'b1, 8'h08, {24'h0, dv[2:0], 3'h0, f[1:0]});
            apb(1'b1, 8'h00, 32'(md));
            wait_frame();
            wait_frame();
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (frame_start_o !== 1'b1 && n < 5000);
            e = 32'(2 * (md + 1) * (dv + 1) * (8 >> f) * TICK);
            cmp(32'(n), e, "period");
            if (n >= 5000) final_report();
        end
        apb(1'b1, 8'h00, 32'h4);
        repeat (200) @(posedge clk_i);
        n = 0;
        repeat (200) begin
            @(posedge clk_i);
            n += (frame_start_o !== 1'b0);
        end
        cmp(32'(n), 32'h0, "halted");
        cmp({31'h0, |{seg_level_o, com_level_o}}, 32'h0, "idle");
        apb(1'b0, 8'h10, 32'h0);
        cmp({31'h0, rd[0]}, 32'h0, "status");
        apb(1'b1, 8'h00, 32'h0);
        wait_frame();
        final_report();
    end
endmodule : tb_top
`default_nettype wire
